// file: design/pmc_pkg.sv
// Purpose : shared constants and types of the power-mode controller
// Assumes : 32-bit register words at byte addresses, 250 MHz system clock
// Notes   : field positions index bits inside the register words
`default_nettype none
package pmc_pkg;
   // ------------------------------------------------------------
   // power modes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      M_POR      = 3'b000,
      M_SHUTDOWN = 3'b001,
      M_SLEEP    = 3'b010,
      M_ACTIVE   = 3'b011,
      M_HWRST    = 3'b100
   } mode_t;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_IDLE_CFG  = 8'h04;
   localparam logic [7:0]  OFS_PWR_CFG   = 8'h08;
   localparam logic [7:0]  OFS_STATUS    = 8'h0c;
   localparam logic [7:0]  OFS_FLAG_CLR  = 8'h10;
   localparam int          CTRL_SLEEP    = 0;
   localparam int          CTRL_SHDN     = 1;
   localparam int          IDLE_EN       = 0;
   localparam int          IDLE_SHDN     = 1;
   localparam int          IDLE_LIM_LSB  = 8;
   localparam int          PWR_DWELL_LSB = 0;
   localparam int          PWR_BAL_SHDN  = 3;
   localparam int          ST_DIGITAL_RESET_FLAG       = 4;
   localparam int          ST_SECLR      = 5;
   localparam logic [31:0] IDLE_CFG_RST  = 32'h0000_0000;
   localparam logic [3:0]  PWR_CFG_RST   = 4'h0;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 4;
   localparam int HWRST_TIME_NS  = 2000;
   localparam int HWRST_CYCLES   = (HWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHDN_LOW_MIN   = 1000;
   localparam int SHDN_LOW_MAX   = 2000;
   localparam int LWAKE_LOW_MIN  = 3000;
   localparam int LWAKE_LOW_MAX  = 4000;
   localparam int WAKE_LOW_MIN   = 5000;
   localparam int WAKE_LOW_MAX   = 8000;
   localparam int HWRST_LOW_MIN  = 10000;
   localparam int HWRST_LOW_MAX  = 20000;
   localparam int SLEEP_UNIT_CYC = 250000;
endpackage : pmc_pkg
`default_nettype wire

// file: design/pmc_ping_det.sv
// Purpose : classify pings on the receive line by the length of their low phase
// Assumes : i_rx already synchronised to i_clk
// Notes   : each output is a one-cycle pulse at the rising edge that ends the ping
`default_nettype none
module pmc_ping_det #(
   parameter int SHDN_MIN  = 1000,
   parameter int SHDN_MAX  = 2000,
   parameter int LWAKE_MIN = 3000,
   parameter int LWAKE_MAX = 4000,
   parameter int WAKE_MIN  = 5000,
   parameter int WAKE_MAX  = 8000,
   parameter int HWRST_MIN = 10000,
   parameter int HWRST_MAX = 20000
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_rx,
   output logic      o_wake,
   output logic      o_lwake,
   output logic      o_shdn,
   output logic      o_hwrst
);
   typedef struct packed {
      logic        rx_prev;
      logic [23:0] low_cnt;
      logic        wake;
      logic        lwake;
      logic        shdn;
      logic        hwrst;
   } det_t;

   det_t s;
   det_t n;

   function automatic logic in_win(input logic [23:0] c, input int lo, input int hi);
      return (c >= 24'(lo)) && (c <= 24'(hi));
   endfunction : in_win

   // ------------------------------------------------------------
   // low-phase timer and classification
   // ------------------------------------------------------------
   always_comb begin
      n         = s;
      n.rx_prev = i_rx;
      n.wake    = 1'b0;
      n.lwake   = 1'b0;
      n.shdn    = 1'b0;
      n.hwrst   = 1'b0;
      if (!i_rx) begin
         if (s.low_cnt != 24'hff_ffff) begin
            n.low_cnt = s.low_cnt + 24'h00_0001;
         end
      end else if (!s.rx_prev) begin
         // high-low-high completed: the low length names the ping
         n.shdn    = in_win(s.low_cnt, SHDN_MIN, SHDN_MAX);
         n.lwake   = in_win(s.low_cnt, LWAKE_MIN, LWAKE_MAX);
         n.wake    = in_win(s.low_cnt, WAKE_MIN, WAKE_MAX);
         n.hwrst   = in_win(s.low_cnt, HWRST_MIN, HWRST_MAX);
         n.low_cnt = 24'h00_0000;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s         <= '0;
         s.rx_prev <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign o_wake  = s.wake;
   assign o_lwake = s.lwake;
   assign o_shdn  = s.shdn;
   assign o_hwrst = s.hwrst;
endmodule : pmc_ping_det
`default_nettype wire

// file: design/pmc_top.sv
// Purpose : power-mode controller of a battery monitor with an AXI4-Lite register port
// Assumes : I_RX, I_OVERTEMP and I_VBAT_OK are asynchronous; other inputs share I_SYS_CLK
// Notes   : register access is refused with SLVERR outside ACTIVE
`default_nettype none
module pmc_top
   import pmc_pkg::*;
#(
   parameter int SHDN_MIN   = pmc_pkg::SHDN_LOW_MIN,
   parameter int SHDN_MAX   = pmc_pkg::SHDN_LOW_MAX,
   parameter int LWAKE_MIN  = pmc_pkg::LWAKE_LOW_MIN,
   parameter int LWAKE_MAX  = pmc_pkg::LWAKE_LOW_MAX,
   parameter int WAKE_MIN   = pmc_pkg::WAKE_LOW_MIN,
   parameter int WAKE_MAX   = pmc_pkg::WAKE_LOW_MAX,
   parameter int HWRST_MIN  = pmc_pkg::HWRST_LOW_MIN,
   parameter int HWRST_MAX  = pmc_pkg::HWRST_LOW_MAX,
   parameter int SLEEP_UNIT = pmc_pkg::SLEEP_UNIT_CYC
) (
   input  wire logic           I_SYS_CLK,
   input  wire logic           I_RESETN,
   input  wire logic           I_RX,
   input  wire logic           I_OVERTEMP,
   input  wire logic           I_VBAT_OK,
   input  wire logic           I_BAL_DONE,
   input  wire logic           I_LINK_ACTIVITY,
   input  wire logic           I_AWVALID,
   input  wire logic [7:0]     I_AWADDR,
   output logic                O_AWREADY,
   input  wire logic           I_WVALID,
   input  wire logic [31:0]    I_WDATA,
   input  wire logic [3:0]     I_WSTRB,
   output logic                O_WREADY,
   output logic                O_BVALID,
   output logic [1:0]          O_BRESP,
   input  wire logic           I_BREADY,
   input  wire logic           I_ARVALID,
   input  wire logic [7:0]     I_ARADDR,
   output logic                O_ARREADY,
   output logic                O_RVALID,
   output logic [31:0]         O_RDATA,
   output logic [1:0]          O_RRESP,
   input  wire logic           I_RREADY,
   output pmc_pkg::mode_t      O_MODE,
   output logic                O_SUPPLIES_ON,
   output logic                O_ACTIVE_FUNC_EN,
   output logic                O_SLEEP_FUNC_EN,
   output logic                O_FAULT_EN,
   output logic                O_SLEEP_TIMER_EN,
   output logic                O_BANDGAP_ONLY,
   output logic                O_DIGITAL_RESET,
   output logic                O_SHADOW_RELOAD,
   output logic                O_SERIAL_RESET
);
   import pmc_pkg::*;

   localparam logic [15:0] HW_LAST = 16'(HWRST_CYCLES - 1);

   typedef struct packed {
      logic rx_m, rx_s, vt_m, vt_s, vb_m, vb_s;
      mode_t       mode;
      logic [15:0] hw_cnt;
      logic [23:0] idle_cnt;
      logic [23:0] dwell_cnt;
      logic [31:0] idle_cfg;
      logic [3:0]  pwr_cfg;
      logic        cmd_sleep, cmd_shdn;
      logic        f_digital_reset_flag, f_seclr;
      logic        aw_ok, w_ok;
      logic [7:0]  aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready, wready, bvalid, arready, rvalid;
      logic [1:0]  bresp, rresp;
      logic [31:0] rdata;
      logic        act_en, slp_en, sup_on, flt_en, tmr_en, bg_only;
      logic        dig_rst, ser_rst;
   } state_t;

   state_t      s;
   state_t      n;
   logic        rs1, rst_n;
   logic        p_wake, p_lwake, p_shdn, p_hwrst;
   logic        act, aw_hs, w_hs, ar_hs, activity, idle_exp, dwell_exp;
   logic [23:0] dwell_lim;
   logic [31:0] stat, wmerge, pmerge;

   function automatic logic mapped(input logic [7:0] a);
      return a inside {OFS_CTRL, OFS_IDLE_CFG, OFS_PWR_CFG, OFS_STATUS, OFS_FLAG_CLR};
   endfunction : mapped

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] b);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (b[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rs1   <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1   <= 1'b1;
         rst_n <= rs1;
      end
   end

   // ------------------------------------------------------------
   // ping detector
   // ------------------------------------------------------------
   pmc_ping_det #(
      .SHDN_MIN (SHDN_MIN),  .SHDN_MAX (SHDN_MAX),
      .LWAKE_MIN(LWAKE_MIN), .LWAKE_MAX(LWAKE_MAX),
      .WAKE_MIN (WAKE_MIN),  .WAKE_MAX (WAKE_MAX),
      .HWRST_MIN(HWRST_MIN), .HWRST_MAX(HWRST_MAX)
   ) u_ping (
      .i_clk  (I_SYS_CLK),
      .i_rst_n(rst_n),
      .i_rx   (s.rx_s),
      .o_wake (p_wake),
      .o_lwake(p_lwake),
      .o_shdn (p_shdn),
      .o_hwrst(p_hwrst)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      n           = s;
      n.rx_m      = I_RX;
      n.rx_s      = s.rx_m;
      n.vt_m      = I_OVERTEMP;
      n.vt_s      = s.vt_m;
      n.vb_m      = I_VBAT_OK;
      n.vb_s      = s.vb_m;
      n.cmd_sleep = 1'b0;
      n.cmd_shdn  = 1'b0;
      n.dig_rst   = 1'b0;
      n.ser_rst   = 1'b0;
      act         = s.mode == M_ACTIVE;
      aw_hs       = I_AWVALID && s.awready;
      w_hs        = I_WVALID && s.wready;
      ar_hs       = I_ARVALID && s.arready;
      activity    = act && (I_LINK_ACTIVITY || aw_hs || ar_hs);
      stat        = 32'h0000_0000;
      stat[2:0]   = s.mode;
      stat[ST_DIGITAL_RESET_FLAG]  = s.f_digital_reset_flag;
      stat[ST_SECLR] = s.f_seclr;
      wmerge      = merge(s.idle_cfg, s.w_data, s.w_strb);
      pmerge      = merge({28'h000_0000, s.pwr_cfg}, s.w_data, s.w_strb);

      // write channel: address and data taken in either order
      if (aw_hs) begin
         n.aw_ok   = 1'b1;
         n.aw_addr = I_AWADDR;
      end
      if (w_hs) begin
         n.w_ok   = 1'b1;
         n.w_data = I_WDATA;
         n.w_strb = I_WSTRB;
      end
      if (s.bvalid && I_BREADY) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_ok && s.w_ok && !s.bvalid) begin
         n.aw_ok  = 1'b0;
         n.w_ok   = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = (act && mapped(s.aw_addr)) ? RESP_OKAY : RESP_SLVERR;
         if (act) begin
            unique case (s.aw_addr)
               OFS_CTRL: begin
                  n.cmd_sleep = s.w_strb[0] && s.w_data[CTRL_SLEEP];
                  n.cmd_shdn  = s.w_strb[0] && s.w_data[CTRL_SHDN];
               end
               OFS_IDLE_CFG: n.idle_cfg = wmerge;
               OFS_PWR_CFG:  n.pwr_cfg  = pmerge[3:0];
               OFS_FLAG_CLR: begin
                  if (s.w_strb[0] && s.w_data[ST_DIGITAL_RESET_FLAG]) begin
                     n.f_digital_reset_flag = 1'b0;
                  end
                  if (s.w_strb[0] && s.w_data[ST_SECLR]) begin
                     n.f_seclr = 1'b0;
                  end
               end
               default: ;
            endcase
         end
      end

      // read channel
      if (s.rvalid && I_RREADY) begin
         n.rvalid = 1'b0;
      end
      if (ar_hs) begin
         n.rvalid = 1'b1;
         n.rresp  = (act && mapped(I_ARADDR)) ? RESP_OKAY : RESP_SLVERR;
         n.rdata  = 32'h0000_0000;
         if (act) begin
            unique case (I_ARADDR)
               OFS_IDLE_CFG: n.rdata = s.idle_cfg;
               OFS_PWR_CFG:  n.rdata = {28'h000_0000, s.pwr_cfg};
               OFS_STATUS:   n.rdata = stat;
               default: ;
            endcase
         end
      end

      // timers
      idle_exp  = act && s.idle_cfg[IDLE_EN] && (s.idle_cnt >= s.idle_cfg[31:IDLE_LIM_LSB]);
      dwell_lim = 24'(int'(s.pwr_cfg[PWR_DWELL_LSB +: 3]) * SLEEP_UNIT);
      dwell_exp = (s.mode == M_SLEEP) && (s.pwr_cfg[PWR_DWELL_LSB +: 3] != 3'h0)
                  && (s.dwell_cnt >= dwell_lim);
      if (!act || activity) begin
         n.idle_cnt = 24'h00_0000;
      end else if (!idle_exp) begin
         n.idle_cnt = s.idle_cnt + 24'h00_0001;
      end
      if (s.mode != M_SLEEP) begin
         n.dwell_cnt = 24'h00_0000;
      end else if (!dwell_exp) begin
         n.dwell_cnt = s.dwell_cnt + 24'h00_0001;
      end

      // power-mode sequencing
      unique case (s.mode)
         M_POR: begin
            if (s.vb_s) begin
               n.mode = M_SHUTDOWN;
            end
         end
         M_SHUTDOWN: begin
            if (p_wake) begin
               n.mode    = M_ACTIVE;
               n.dig_rst = 1'b1;
               n.ser_rst = 1'b1;
               n.f_digital_reset_flag  = 1'b1;
               n.f_seclr = 1'b1;
            end
         end
         M_HWRST: begin
            n.hw_cnt = s.hw_cnt + 16'h0001;
            if (s.hw_cnt == HW_LAST) begin
               n.mode = M_SHUTDOWN;
            end
         end
         M_SLEEP, M_ACTIVE: begin
            if (p_hwrst) begin
               n.mode   = M_HWRST;
               n.hw_cnt = 16'h0000;
            end else if (s.vt_s) begin
               n.mode = M_SHUTDOWN;
            end else if (p_shdn) begin
               n.mode = M_SHUTDOWN;
            end else if (p_wake) begin
               n.mode    = M_ACTIVE;
               n.dig_rst = 1'b1;
               n.f_digital_reset_flag  = 1'b1;
            end else if (p_lwake) begin
               n.mode    = M_ACTIVE;
               n.ser_rst = 1'b1;
               n.f_seclr = 1'b1;
            end else if (I_BAL_DONE && s.pwr_cfg[PWR_BAL_SHDN]) begin
               n.mode = M_SHUTDOWN;
            end else if (dwell_exp) begin
               n.mode = M_SHUTDOWN;
            end else if (act && s.cmd_shdn) begin
               n.mode = M_SHUTDOWN;
            end else if (act && s.cmd_sleep) begin
               n.mode = M_SLEEP;
            end else if (idle_exp) begin
               n.mode = s.idle_cfg[IDLE_SHDN] ? M_SHUTDOWN : M_SLEEP;
            end
         end
         default: n.mode = M_POR;
      endcase
      if (n.dig_rst) begin
         n.idle_cfg = IDLE_CFG_RST;
         n.pwr_cfg  = PWR_CFG_RST;
      end
      if (!s.vb_s) begin
         n.mode    = M_POR;
         n.dig_rst = 1'b0;
         n.ser_rst = 1'b0;
      end

      // handshake readiness and mode-gated enables
      n.awready = !n.aw_ok && !n.bvalid;
      n.wready  = !n.w_ok && !n.bvalid;
      n.arready = !n.rvalid;
      n.act_en  = n.mode == M_ACTIVE;
      n.slp_en  = n.mode inside {M_SLEEP, M_ACTIVE};
      n.sup_on  = n.mode inside {M_SLEEP, M_ACTIVE};
      n.flt_en  = n.mode inside {M_SLEEP, M_ACTIVE};
      n.tmr_en  = n.mode == M_SLEEP;
      n.bg_only = n.mode == M_HWRST;
   end

   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         s          <= '0;
         // receive line idles high: no false ping edge after reset
         s.rx_m     <= 1'b1;
         s.rx_s     <= 1'b1;
         s.idle_cfg <= IDLE_CFG_RST;
         s.pwr_cfg  <= PWR_CFG_RST;
      end else begin
         s <= n;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign O_AWREADY        = s.awready;
   assign O_WREADY         = s.wready;
   assign O_BVALID         = s.bvalid;
   assign O_BRESP          = s.bresp;
   assign O_ARREADY        = s.arready;
   assign O_RVALID         = s.rvalid;
   assign O_RDATA          = s.rdata;
   assign O_RRESP          = s.rresp;
   assign O_MODE           = s.mode;
   assign O_SUPPLIES_ON    = s.sup_on;
   assign O_ACTIVE_FUNC_EN = s.act_en;
   assign O_SLEEP_FUNC_EN  = s.slp_en;
   assign O_FAULT_EN       = s.flt_en;
   assign O_SLEEP_TIMER_EN = s.tmr_en;
   assign O_BANDGAP_ONLY   = s.bg_only;
   assign O_DIGITAL_RESET  = s.dig_rst;
   assign O_SHADOW_RELOAD  = s.dig_rst;
   assign O_SERIAL_RESET   = s.ser_rst;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   por_all_off_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      !s.vb_s |=> s.mode == M_POR ##0 !O_SUPPLIES_ON && !O_FAULT_EN && !O_BANDGAP_ONLY)
      else $error("low battery did not hold power-on-reset");
   shdn_stays_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_SHUTDOWN && s.vb_s && !p_wake |=> s.mode == M_SHUTDOWN)
      else $error("shutdown left without a wake ping");
   wake_flags_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_SHUTDOWN && s.vb_s && p_wake |=>
      s.mode == M_ACTIVE && s.f_digital_reset_flag && s.f_seclr && O_DIGITAL_RESET && O_SHADOW_RELOAD)
      else $error("wake from shutdown missed reset or flags");
   thermal_wins_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode inside {M_SLEEP, M_ACTIVE} && s.vt_s && s.vb_s && !p_hwrst |=> s.mode == M_SHUTDOWN)
      else $error("over-temperature did not force shutdown");
   hwrst_hold_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_HWRST && s.vb_s |=> (s.mode == M_HWRST) == ($past(s.hw_cnt) != HW_LAST))
      else $error("hard-reset interval has the wrong length");
   hwrst_prio_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode inside {M_SLEEP, M_ACTIVE} && p_hwrst && s.vb_s |=> s.mode == M_HWRST && s.hw_cnt == 16'h0000
      ##1 O_BANDGAP_ONLY && !O_SUPPLIES_ON)
      else $error("hard-reset ping did not win");
   sleep_entry_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      $rose(s.mode == M_SLEEP) |-> $past(s.mode) == M_ACTIVE)
      else $error("sleep entered from a mode other than active");
   sleep_gating_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_SLEEP |-> !O_ACTIVE_FUNC_EN && O_SLEEP_FUNC_EN && O_FAULT_EN && O_SLEEP_TIMER_EN)
      else $error("sleep enables are wrong");
   lwake_path_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_SLEEP && s.vb_s && p_lwake && !p_hwrst && !s.vt_s && !p_shdn && !p_wake |=>
      s.mode == M_ACTIVE && O_SERIAL_RESET && !O_DIGITAL_RESET && s.f_seclr)
      else $error("light wake took the wrong path");
   cmd_shdn_a: assert property (
      @(posedge I_SYS_CLK) disable iff (!rst_n)
      s.mode == M_ACTIVE && s.cmd_shdn && s.vb_s && !p_hwrst && !p_lwake && !p_wake |=> s.mode == M_SHUTDOWN)
      else $error("shutdown request ignored");
endmodule : pmc_top
`default_nettype wire

// file: testbench/pmc_host_model.sv
// Purpose : host side of the receive line, sends pings
// Assumes : line idles high through its pull-up
// Notes   : low phase counted in system clock cycles
`default_nettype none
module pmc_host_model (
   input  wire logic i_clk,
   output logic      o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_rx = 1'b1;
   task ping(input int low);
      @(posedge i_clk);
      o_rx <= 1'b0;
      repeat (low) @(posedge i_clk);
      o_rx <= 1'b1;
   endtask : ping
endmodule : pmc_host_model
`default_nettype wire

// file: testbench/tb_pmc_top.sv
// Purpose : self-checking bench of the power-mode controller
// Assumes : short wake and hard-reset ping windows and sleep unit
// Notes   : bus tasks hold each request until it is taken
`default_nettype none
module tb_pmc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmc_pkg::*;
   logic clk = 0, rst_n = 0, vbat = 0, hot = 0, aw = 0, wv = 0, br = 0, ar = 0, rr = 0, bal = 0, lact = 0;
   logic [3:0] ws = 4'hf;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdata;
   logic [1:0] bresp, rresp;
   logic awr, wrd, bv, arr, rv, afe, sfe, ste, bgo, drs, shr, srs, rx, sup, fen;
   mode_t mode;
   int n_errors = 0, total_checks = 0, cyc = 0;
   pmc_host_model u_host (.i_clk(clk), .o_rx(rx));
   pmc_top #(.WAKE_MIN(50), .WAKE_MAX(80), .HWRST_MIN(100), .HWRST_MAX(200), .SLEEP_UNIT(10)) u_dut (
      .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_RX(rx), .I_OVERTEMP(hot), .I_VBAT_OK(vbat),
      .I_BAL_DONE(bal), .I_LINK_ACTIVITY(lact), .I_AWVALID(aw), .I_AWADDR(awa), .O_AWREADY(awr),
      .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wrd), .O_BVALID(bv), .O_BRESP(bresp),
      .I_BREADY(br), .I_ARVALID(ar), .I_ARADDR(ara), .O_ARREADY(arr), .O_RVALID(rv),
      .O_RDATA(rdata), .O_RRESP(rresp), .I_RREADY(rr), .O_MODE(mode), .O_SUPPLIES_ON(sup),
      .O_ACTIVE_FUNC_EN(afe), .O_SLEEP_FUNC_EN(sfe), .O_FAULT_EN(fen), .O_SLEEP_TIMER_EN(ste),
      .O_BANDGAP_ONLY(bgo), .O_DIGITAL_RESET(drs), .O_SHADOW_RELOAD(shr), .O_SERIAL_RESET(srs));
   always #2 clk = ~clk;
   task conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : chk
   task wm(input mode_t m);
      for (int i = 0; i < 1000 && mode !== m; i++) @(posedge clk);
      chk(32'(mode), 32'(m));
   endtask : wm
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      aw <= 1; wv <= 1; awa <= a; wd <= d; br <= 1;
      do begin
         @(posedge clk);
         if (aw && awr) aw <= 0;
         if (wv && wrd) wv <= 0;
      end while (bv !== 1'b1);
      br <= 0;
      chk(32'(bresp), 32'(e));
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
      @(posedge clk);
      ar <= 1; ara <= a; rr <= 1;
      do begin
         @(posedge clk);
         if (ar && arr) ar <= 0;
      end while (rv !== 1'b1);
      rr <= 0;
      chk(rdata, x);
      chk(32'(rresp), 32'(e));
   endtask : rd
   task wake;
      u_host.ping(60);
      wm(M_ACTIVE);
   endtask : wake
   task t_por;
      repeat (10) @(posedge clk);
      chk(32'(mode), 32'(M_POR));
      chk({30'h0, sup, fen}, 32'h0);
      vbat <= 1;
      wm(M_SHUTDOWN);
      wr(OFS_CTRL, 32'h2, RESP_SLVERR);
      rd(OFS_STATUS, 32'h0, RESP_SLVERR);
      u_host.ping(1500);
      u_host.ping(150);
      repeat (30) @(posedge clk);
      chk(32'(mode), 32'(M_SHUTDOWN));
   endtask : t_por
   task t_wake;
      wake();
      chk({29'h0, drs, shr, srs}, 32'h7);
      chk({29'h0, sup, fen, afe}, 32'h7);
      rd(OFS_STATUS, 32'h33, RESP_OKAY);
      wr(OFS_FLAG_CLR, 32'h30, RESP_OKAY);
      rd(OFS_STATUS, 32'h03, RESP_OKAY);
   endtask : t_wake
   task t_sleep;
      ws <= 4'h2;
      wr(OFS_IDLE_CFG, 32'hffff_ff00, RESP_OKAY);
      ws <= 4'hf;
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      wm(M_SLEEP);
      chk({27'h0, sup, fen, afe, sfe, ste}, 32'h1b);
      rd(OFS_STATUS, 32'h0, RESP_SLVERR);
      u_host.ping(3500);
      wm(M_ACTIVE);
      chk({30'h0, srs, drs}, 32'h2);
      rd(OFS_IDLE_CFG, 32'h0000_ff00, RESP_OKAY);
      rd(OFS_STATUS, 32'h23, RESP_OKAY);
      wr(OFS_FLAG_CLR, 32'h30, RESP_OKAY);
   endtask : t_sleep
   task t_sleep_wake;
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      wm(M_SLEEP);
      wake();
      chk({30'h0, srs, drs}, 32'h1);
      rd(OFS_STATUS, 32'h13, RESP_OKAY);
      rd(OFS_IDLE_CFG, 32'h0, RESP_OKAY);
      wr(OFS_IDLE_CFG, 32'h0000_ff00, RESP_OKAY);
      rd(OFS_IDLE_CFG, 32'h0000_ff00, RESP_OKAY);
   endtask : t_sleep_wake
   task t_idle;
      lact <= 1;
      wr(OFS_IDLE_CFG, 32'h0000_0501, RESP_OKAY);
      repeat (20) @(posedge clk);
      chk(32'(mode), 32'(M_ACTIVE));
      lact <= 0;
      wm(M_SLEEP);
      wake();
      wr(OFS_IDLE_CFG, 32'h0000_0503, RESP_OKAY);
      wm(M_SHUTDOWN);
      wake();
      rd(OFS_IDLE_CFG, 32'h0, RESP_OKAY);
   endtask : t_idle
   task t_bal;
      bal <= 1;
      repeat (5) @(posedge clk);
      chk(32'(mode), 32'(M_ACTIVE));
      wr(OFS_PWR_CFG, 32'h8, RESP_OKAY);
      wm(M_SHUTDOWN);
      bal <= 0;
      wake();
   endtask : t_bal
   // dwell limit 2 units of 10 cycles: leaves sleep after 21 cycles
   task t_dwell;
      wr(OFS_PWR_CFG, 32'h2, RESP_OKAY);
      wr(OFS_CTRL, 32'h1, RESP_OKAY);
      wm(M_SLEEP);
      repeat (18) @(posedge clk);
      chk(32'(mode), 32'(M_SLEEP));
      repeat (4) @(posedge clk);
      chk(32'(mode), 32'(M_SHUTDOWN));
      wake();
   endtask : t_dwell
   task t_shdn;
      hot <= 1;
      wm(M_SHUTDOWN);
      hot <= 0;
      wake();
      u_host.ping(1500);
      wm(M_SHUTDOWN);
      chk({29'h0, sup, fen, afe}, 32'h0);
      wake();
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wm(M_SHUTDOWN);
      wake();
   endtask : t_shdn
   task t_hwrst;
      int cnt;
      u_host.ping(150);
      wm(M_HWRST);
      chk({30'h0, bgo, sup}, 32'h2);
      for (cnt = 1; cnt < 1000; cnt++) begin
         @(posedge clk);
         if (mode !== M_HWRST) break;
      end
      chk(32'(cnt), 32'(HWRST_CYCLES));
      chk(32'(mode), 32'(M_SHUTDOWN));
   endtask : t_hwrst
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      t_por();
      t_wake();
      t_sleep();
      t_sleep_wake();
      t_idle();
      t_bal();
      t_dwell();
      t_shdn();
      t_hwrst();
      conclude();
   end
endmodule : tb_pmc_top
`default_nettype wire
